// ===== include/rpcs_pkg.sv
// Package of register map, field layout and carrier types for the counter
package rpcs_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [4:0] RPCS_IDX_CTL_A     = 5'h00;
  localparam logic [4:0] RPCS_IDX_BUSY      = 5'h01;
  localparam logic [4:0] RPCS_IDX_IRQ_EN    = 5'h02;
  localparam logic [4:0] RPCS_IDX_IRQ_FLAGS = 5'h03;
  localparam logic [4:0] RPCS_IDX_LATCH     = 5'h04;
  localparam logic [4:0] RPCS_IDX_DBG       = 5'h05;
  localparam logic [4:0] RPCS_IDX_CLK_SRC   = 5'h07;
  localparam logic [4:0] RPCS_IDX_VALUE     = 5'h08;
  localparam logic [4:0] RPCS_IDX_TOP       = 5'h0a;
  localparam logic [4:0] RPCS_IDX_MATCH     = 5'h0c;
  localparam logic [4:0] RPCS_IDX_PCTL      = 5'h10;
  localparam logic [4:0] RPCS_IDX_PSTAT     = 5'h11;
  localparam logic [4:0] RPCS_IDX_PIRQ_EN   = 5'h12;
  localparam logic [4:0] RPCS_IDX_PIRQ_FLG  = 5'h13;
  localparam logic [4:0] RPCS_IDX_PDBG      = 5'h15;

  // Field positions
  localparam int RPCS_BIT_RUN_STBY = 7;
  localparam int RPCS_PRESC_LSB    = 3;
  localparam int RPCS_PRESC_W      = 4;
  localparam int RPCS_BIT_ENABLE   = 0;
  localparam int RPCS_PERIOD_LSB   = 3;
  localparam int RPCS_PERIOD_W     = 4;
  localparam int RPCS_BIT_OVF      = 0;
  localparam int RPCS_BIT_MATCH    = 1;
  localparam int RPCS_BUSY_CTL_A   = 0;
  localparam int RPCS_BUSY_VALUE   = 1;
  localparam int RPCS_BUSY_TOP     = 2;
  localparam int RPCS_BUSY_MATCH   = 3;
  localparam int RPCS_BUSY_PCTL    = 4;
  localparam int RPCS_NUM_BUSY     = 5;

  // Reset values
  localparam logic [7:0]  RPCS_RST_BYTE = 8'h00;
  localparam logic [15:0] RPCS_RST_VALUE = 16'h0000;
  localparam logic [15:0] RPCS_RST_TOP   = 16'hffff;
  localparam logic [15:0] RPCS_RST_MATCH = 16'h0000;

  // Counter-clock edges between a write and its effect
  localparam logic [1:0] RPCS_SYNC_EDGES = 2'h2;

  // Prescaler width: division up to 2^15
  localparam int RPCS_PRESC_BITS = 15;

  // Accepted AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [4:0] idx;
  } rpcs_req_s;

  // Interrupt and timer outputs
  typedef struct packed {
    logic counter_irq;
    logic periodic_irq;
    logic periodic_out;
  } rpcs_irq_s;

endpackage : rpcs_pkg

// ===== hw/rpcs_top.sv
// Counter and periodic timer with register bus, sync and debug control
`timescale 1ns/1ps

module rpcs_top
  import rpcs_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Counter clock pin and system state
  input  wire logic        counter_clk_pin,
  input  wire logic        cpu_halted,
  input  wire logic        sleep_standby,
  // Interrupts and periodic output
  output logic             counter_irq,
  output logic             periodic_irq,
  output logic             periodic_out
);

  // Counter clock synchronizer and edge detect
  logic clk_sync1_q;
  logic clk_sync2_q;
  logic clk_prev_q;
  logic ctr_edge;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_sync1_q <= 1'b0;
      clk_sync2_q <= 1'b0;
      clk_prev_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      clk_sync1_q <= counter_clk_pin;
      clk_sync2_q <= clk_sync1_q;
      clk_prev_q  <= clk_sync2_q;
    end
  end

  assign ctr_edge = clk_sync2_q & ~clk_prev_q;

  // Software-facing copies
  logic [7:0]  ctl_a_q,     ctl_a_d;
  logic [1:0]  irq_en_q,    irq_en_d;
  logic [1:0]  flags_q,     flags_d;
  logic [7:0]  latch_q,     latch_d;
  logic        dbg_run_q,   dbg_run_d;
  logic [1:0]  clk_src_q,   clk_src_d;
  logic [15:0] value_wr_q,  value_wr_d;
  logic [15:0] top_q,       top_d;
  logic [15:0] match_q,     match_d;
  logic [7:0]  pctl_q,      pctl_d;
  logic        pirq_en_q,   pirq_en_d;
  logic        pflag_q,     pflag_d;
  logic        pdbg_run_q,  pdbg_run_d;
  // Counter-domain effective copies
  logic [7:0]  ctl_a_eff_q, ctl_a_eff_d;
  logic [15:0] value_q,     value_d;
  logic [15:0] top_eff_q,   top_eff_d;
  logic [15:0] match_eff_q, match_eff_d;
  logic [7:0]  pctl_eff_q,  pctl_eff_d;
  logic [RPCS_PRESC_BITS-1:0] presc_q, presc_d;
  // Synchronization tracking
  logic [RPCS_NUM_BUSY-1:0] busy_q, busy_d;
  logic [1:0]  sync_cnt_q [RPCS_NUM_BUSY];
  logic [1:0]  sync_cnt_d [RPCS_NUM_BUSY];
  logic [RPCS_NUM_BUSY-1:0] wr_hit;
  logic [RPCS_NUM_BUSY-1:0] apply;
  // Bus and outputs
  rpcs_req_s   req_q,       req_d;
  logic [31:0] hrdata_q,    hrdata_d;
  logic        hreadyout_q, hreadyout_d;
  rpcs_irq_s   irq_q,       irq_d;

  // Decoded write and read strobes
  logic        wr_act;
  logic [4:0]  wr_idx;
  logic        rd_pend;

  assign wr_act  = req_q.valid & req_q.write;
  assign wr_idx  = req_q.idx;
  assign rd_pend = req_q.valid & ~req_q.write;

  always_comb
  begin
    wr_hit                  = '0;
    wr_hit[RPCS_BUSY_CTL_A] = wr_act && (wr_idx == RPCS_IDX_CTL_A);
    wr_hit[RPCS_BUSY_VALUE] = wr_act && (wr_idx == RPCS_IDX_VALUE);
    wr_hit[RPCS_BUSY_TOP]   = wr_act && (wr_idx == RPCS_IDX_TOP);
    wr_hit[RPCS_BUSY_MATCH] = wr_act && (wr_idx == RPCS_IDX_MATCH);
    wr_hit[RPCS_BUSY_PCTL]  = wr_act && (wr_idx == RPCS_IDX_PCTL);
  end

  // Busy tracking: a write restarts the count even if one completes now
  always_comb
  begin
    busy_d = busy_q;
    apply  = '0;
    for (int i = 0; i < RPCS_NUM_BUSY; i++)
    begin
      sync_cnt_d[i] = sync_cnt_q[i];
      if (wr_hit[i])
      begin
        busy_d[i]     = 1'b1;
        sync_cnt_d[i] = 2'h0;
      end
      else if (busy_q[i] && ctr_edge)
      begin
        if (sync_cnt_q[i] == RPCS_SYNC_EDGES - 2'h1)
        begin
          apply[i]      = 1'b1;
          busy_d[i]     = 1'b0;
          sync_cnt_d[i] = 2'h0;
        end
        else
        begin
          sync_cnt_d[i] = sync_cnt_q[i] + 2'h1;
        end
      end
    end
  end

  // Counter-domain behaviour
  logic [RPCS_PRESC_W-1:0]    presc_sel;
  logic [RPCS_PERIOD_W-1:0]   period_sel;
  logic [RPCS_PRESC_BITS-1:0] presc_mask;
  logic                       ctr_en;
  logic                       pit_en;
  logic                       ctr_run;
  logic                       ctr_tick;
  logic                       pout_raw;
  logic                       pout_gated;
  logic                       ovf_set;
  logic                       match_set;
  logic                       pflag_set;

  always_comb
  begin
    presc_sel  = ctl_a_eff_q[RPCS_PRESC_LSB +: RPCS_PRESC_W];
    period_sel = pctl_eff_q[RPCS_PERIOD_LSB +: RPCS_PERIOD_W];
    ctr_en     = ctl_a_eff_q[RPCS_BIT_ENABLE];
    pit_en     = pctl_eff_q[RPCS_BIT_ENABLE];
    // Mask of low prescaler bits that must be all ones for a tick
    presc_mask = ~({RPCS_PRESC_BITS{1'b1}} << presc_sel);
    ctr_run    = ctr_en && (!sleep_standby || ctl_a_eff_q[RPCS_BIT_RUN_STBY])
                 && (dbg_run_q || !cpu_halted);
    ctr_tick   = ctr_edge && ctr_run && ((presc_q & presc_mask) == presc_mask);
    // Codes 0 and 15 leave the periodic output off
    pout_raw   = pit_en && (period_sel != 4'h0) && (period_sel != 4'hf)
                 && presc_q[period_sel];
    // Periodic timer ignores sleep state entirely
    pout_gated = pout_raw && !(cpu_halted && !pdbg_run_q);

    presc_d = presc_q;
    if (ctr_edge && (ctr_en || pit_en))
    begin
      presc_d = presc_q + 1'b1;
    end
    else if (!ctr_en && !pit_en)
    begin
      presc_d = '0;
    end

    value_d   = value_q;
    ovf_set   = 1'b0;
    match_set = 1'b0;
    if (ctr_tick)
    begin
      match_set = (value_q == match_eff_q);
      if (value_q == top_eff_q)
      begin
        value_d = RPCS_RST_VALUE;
        ovf_set = 1'b1;
      end
      else
      begin
        value_d = value_q + 16'h0001;
      end
    end
    if (apply[RPCS_BUSY_VALUE])
    begin
      value_d = value_wr_q;
    end

    ctl_a_eff_d = apply[RPCS_BUSY_CTL_A] ? ctl_a_q : ctl_a_eff_q;
    top_eff_d   = apply[RPCS_BUSY_TOP]   ? top_q   : top_eff_q;
    match_eff_d = apply[RPCS_BUSY_MATCH] ? match_q : match_eff_q;
    pctl_eff_d  = apply[RPCS_BUSY_PCTL]  ? pctl_q  : pctl_eff_q;

    // Rising edge of the gated output, so a break from high adds one
    pflag_set = pout_gated && !irq_q.periodic_out;
  end

  // Register bus: writes in the data phase, reads one wait state
  always_comb
  begin
    req_d       = '0;
    hreadyout_d = 1'b1;
    hrdata_d    = hrdata_q;
    if (hsel && htrans[1] && hready)
    begin
      req_d.valid = 1'b1;
      req_d.write = hwrite;
      req_d.idx   = haddr[6:2];
      hreadyout_d = hwrite;
    end
    if (rd_pend)
    begin
      hrdata_d = 32'h0000_0000;
      unique case (req_q.idx)
        RPCS_IDX_CTL_A:     hrdata_d[7:0]  = ctl_a_q;
        RPCS_IDX_BUSY:      hrdata_d[3:0]  = busy_q[3:0];
        RPCS_IDX_IRQ_EN:    hrdata_d[1:0]  = irq_en_q;
        RPCS_IDX_IRQ_FLAGS: hrdata_d[1:0]  = flags_q;
        RPCS_IDX_LATCH:     hrdata_d[7:0]  = latch_q;
        RPCS_IDX_DBG:       hrdata_d[0]    = dbg_run_q;
        RPCS_IDX_CLK_SRC:   hrdata_d[1:0]  = clk_src_q;
        RPCS_IDX_VALUE:     hrdata_d[15:0] = value_q;
        RPCS_IDX_TOP:       hrdata_d[15:0] = top_q;
        RPCS_IDX_MATCH:     hrdata_d[15:0] = match_q;
        RPCS_IDX_PCTL:      hrdata_d[7:0]  = pctl_q;
        RPCS_IDX_PSTAT:     hrdata_d[0]    = busy_q[RPCS_BUSY_PCTL];
        RPCS_IDX_PIRQ_EN:   hrdata_d[0]    = pirq_en_q;
        RPCS_IDX_PIRQ_FLG:  hrdata_d[0]    = pflag_q;
        RPCS_IDX_PDBG:      hrdata_d[0]    = pdbg_run_q;
        default:            hrdata_d       = 32'h0000_0000;
      endcase
    end
  end

  // Software register writes and flag handling; set beats clear
  always_comb
  begin
    ctl_a_d    = ctl_a_q;
    irq_en_d   = irq_en_q;
    latch_d    = latch_q;
    dbg_run_d  = dbg_run_q;
    clk_src_d  = clk_src_q;
    value_wr_d = value_wr_q;
    top_d      = top_q;
    match_d    = match_q;
    pctl_d     = pctl_q;
    pirq_en_d  = pirq_en_q;
    pdbg_run_d = pdbg_run_q;
    flags_d    = flags_q;
    pflag_d    = pflag_q;
    if (wr_act)
    begin
      unique case (wr_idx)
        RPCS_IDX_CTL_A:     ctl_a_d    = {hwdata[7:3], 2'b00, hwdata[0]};
        RPCS_IDX_IRQ_EN:    irq_en_d   = hwdata[1:0];
        RPCS_IDX_IRQ_FLAGS: flags_d    = flags_q & ~hwdata[1:0];
        RPCS_IDX_LATCH:     latch_d    = hwdata[7:0];
        RPCS_IDX_DBG:       dbg_run_d  = hwdata[0];
        RPCS_IDX_CLK_SRC:   clk_src_d  = hwdata[1:0];
        RPCS_IDX_VALUE:     value_wr_d = hwdata[15:0];
        RPCS_IDX_TOP:       top_d      = hwdata[15:0];
        RPCS_IDX_MATCH:     match_d    = hwdata[15:0];
        RPCS_IDX_PCTL:      pctl_d     = {1'b0, hwdata[6:3], 2'b00, hwdata[0]};
        RPCS_IDX_PIRQ_EN:   pirq_en_d  = hwdata[0];
        RPCS_IDX_PIRQ_FLG:  pflag_d    = pflag_q & ~hwdata[0];
        RPCS_IDX_PDBG:      pdbg_run_d = hwdata[0];
        default:            ;
      endcase
    end
    if (ovf_set)
    begin
      flags_d[RPCS_BIT_OVF] = 1'b1;
    end
    if (match_set)
    begin
      flags_d[RPCS_BIT_MATCH] = 1'b1;
    end
    if (pflag_set)
    begin
      pflag_d = 1'b1;
    end
    irq_d.counter_irq  = |(flags_d & irq_en_d);
    irq_d.periodic_irq = pflag_d & pirq_en_d;
    irq_d.periodic_out = pout_gated;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl_a_q     <= RPCS_RST_BYTE;
      irq_en_q    <= '0;
      flags_q     <= '0;
      latch_q     <= RPCS_RST_BYTE;
      dbg_run_q   <= 1'b0;
      clk_src_q   <= '0;
      value_wr_q  <= RPCS_RST_VALUE;
      top_q       <= RPCS_RST_TOP;
      match_q     <= RPCS_RST_MATCH;
      pctl_q      <= RPCS_RST_BYTE;
      pirq_en_q   <= 1'b0;
      pflag_q     <= 1'b0;
      pdbg_run_q  <= 1'b0;
      ctl_a_eff_q <= RPCS_RST_BYTE;
      value_q     <= RPCS_RST_VALUE;
      top_eff_q   <= RPCS_RST_TOP;
      match_eff_q <= RPCS_RST_MATCH;
      pctl_eff_q  <= RPCS_RST_BYTE;
      presc_q     <= '0;
      busy_q      <= '0;
      for (int i = 0; i < RPCS_NUM_BUSY; i++)
      begin
        sync_cnt_q[i] <= 2'h0;
      end
      req_q       <= '0;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      irq_q       <= '0;
    end
    else if (clk_en)
    begin
      ctl_a_q     <= ctl_a_d;
      irq_en_q    <= irq_en_d;
      flags_q     <= flags_d;
      latch_q     <= latch_d;
      dbg_run_q   <= dbg_run_d;
      clk_src_q   <= clk_src_d;
      value_wr_q  <= value_wr_d;
      top_q       <= top_d;
      match_q     <= match_d;
      pctl_q      <= pctl_d;
      pirq_en_q   <= pirq_en_d;
      pflag_q     <= pflag_d;
      pdbg_run_q  <= pdbg_run_d;
      ctl_a_eff_q <= ctl_a_eff_d;
      value_q     <= value_d;
      top_eff_q   <= top_eff_d;
      match_eff_q <= match_eff_d;
      pctl_eff_q  <= pctl_eff_d;
      presc_q     <= presc_d;
      busy_q      <= busy_d;
      for (int i = 0; i < RPCS_NUM_BUSY; i++)
      begin
        sync_cnt_q[i] <= sync_cnt_d[i];
      end
      req_q       <= req_d;
      hrdata_q    <= hrdata_d;
      hreadyout_q <= hreadyout_d;
      irq_q       <= irq_d;
    end
  end

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = 1'b0;
  assign counter_irq  = irq_q.counter_irq;
  assign periodic_irq = irq_q.periodic_irq;
  assign periodic_out = irq_q.periodic_out;

endmodule : rpcs_top

// ===== testbench/rpcs_properties.sv
// Port-level checks for the counter and periodic timer block
`timescale 1ns/1ps

module rpcs_properties
  import rpcs_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Timer side
  input wire logic        counter_clk_pin,
  input wire logic        cpu_halted,
  input wire logic        counter_irq,
  input wire logic        periodic_irq,
  input wire logic        periodic_out
);
  logic       take;
  logic       wtake;
  logic [4:0] idx;
  logic       wph_q;
  logic [4:0] widx_q;
  logic       pin_q;
  logic [3:0] since_q;
  logic       pen_q;
  logic       pdbg_q;

  assign take  = hsel && htrans[1] && hready && clk_en;
  assign wtake = take && hwrite;
  assign idx   = haddr[6:2];

  // Mirrors of two plain bits and the age of the last counter edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wph_q   <= 1'b0;
      widx_q  <= 5'h00;
      pin_q   <= 1'b0;
      since_q <= 4'h0;
      pen_q   <= 1'b0;
      pdbg_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_q   <= counter_clk_pin;
      since_q <= (counter_clk_pin && !pin_q) || cpu_halted ? 4'h0
                 : since_q + {3'h0, ~&since_q};
      if (hready)
      begin
        wph_q  <= wtake;
        widx_q <= idx;
      end
      if (wph_q && hready && widx_q == RPCS_IDX_PIRQ_EN)
        pen_q <= hwdata[0];
      if (wph_q && hready && widx_q == RPCS_IDX_PDBG)
        pdbg_q <= hwdata[0];
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  read_wait_a:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  write_fast_a:
    assert property (wtake |=> hreadyout)
    else $error("write data phase stalled");
  resp_okay_a:
    assert property (hresp == 1'b0)
    else $error("response not okay");
  pirq_clear_a:
    assert property ($fell(periodic_irq) |-> $past(wtake, 2) &&
      ($past(idx, 2) == RPCS_IDX_PIRQ_EN || $past(idx, 2) == RPCS_IDX_PIRQ_FLG))
    else $error("periodic request dropped without a write");
  cirq_clear_a:
    assert property ($fell(counter_irq) |-> $past(wtake, 2) &&
      ($past(idx, 2) == RPCS_IDX_IRQ_EN || $past(idx, 2) == RPCS_IDX_IRQ_FLAGS))
    else $error("counter request dropped without a write");
  cirq_tick_a:
    assert property ($rose(counter_irq) |-> since_q < 4'h6 || $past(wtake, 2))
    else $error("counter request rose away from a tick");
  halt_low_a:
    assert property ((cpu_halted && !pdbg_q) [*2] |-> !periodic_out)
    else $error("periodic output high during halt");
  pit_edge_a:
    assert property ($changed(periodic_out) |-> since_q < 4'h6)
    else $error("periodic output moved away from a counter edge");
  pirq_set_a:
    assert property ($rose(periodic_out) && pen_q |-> ##[0:2] periodic_irq)
    else $error("periodic request missing after output rise");
  freeze_a:
    assert property (!clk_en |=> $stable(periodic_out) &&
      $stable(counter_irq) && $stable(periodic_irq))
    else $error("outputs moved while clock enable low");

  read_done_c: cover property (take && !hwrite);
  pit_irq_c:   cover property ($rose(periodic_irq));
  cnt_irq_c:   cover property ($rose(counter_irq));

endmodule : rpcs_properties

// ===== testbench/tb_rtc_pit_control_sync.sv
// Self-checking bench for the counter and periodic timer block
`timescale 1ns/1ps

module tb_rtc_pit_control_sync
  import rpcs_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        counter_clk_pin = 1'b0;
  logic        cpu_halted = 1'b0;
  logic        sleep_standby = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        counter_irq;
  logic        periodic_irq;
  logic        periodic_out;
  logic [2:0]  pin_div = 3'h0;
  logic [31:0] rdata;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #2.5 hclk = ~hclk;

  // Counter clock: sixteen bus cycles per period
  always @(posedge hclk)
  begin
    pin_div <= pin_div + 3'h1;
    if (pin_div == 3'h7)
      counter_clk_pin <= ~counter_clk_pin;
  end

  rpcs_top u_dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .counter_clk_pin(counter_clk_pin), .cpu_halted(cpu_halted),
    .sleep_standby(sleep_standby), .counter_irq(counter_irq),
    .periodic_irq(periodic_irq), .periodic_out(periodic_out)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic hang(input int n);
    if (n >= 400)
    begin
      error_cnt++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
    end
  endtask : hang

  // Values seen at a negedge are those the next rising edge samples
  task automatic wait_rdy();
    int   n;
    logic r;
    n = 0;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      rdata = hrdata;
      n++;
      @(posedge hclk);
    end while (r !== 1'b1 && n < 400);
    hang(r === 1'b1 ? 0 : n);
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [4:0] i,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {25'h0, i, 2'h0};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : xfer

  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    xfer(1'b1, i, d);
  endtask : wr

  task automatic rdc(input logic [4:0] i, input logic [31:0] exp);
    xfer(1'b0, i, 32'h0);
    chk(rdata, exp);
  endtask : rdc

  // Poll both busy registers before the next synchronized write
  task automatic settle();
    int          n;
    logic [31:0] b;
    n = 0;
    do
    begin
      xfer(1'b0, RPCS_IDX_PSTAT, 32'h0);
      b = rdata;
      xfer(1'b0, RPCS_IDX_BUSY, 32'h0);
      n++;
    end while ((rdata | b) !== 32'h0 && n < 60);
    chk(rdata | b, 32'h0);
    if ((rdata | b) !== 32'h0)
      hang(400);
  endtask : settle

  task automatic look(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : look

  task automatic wait_out(input logic v, output int c);
    c = 0;
    do
    begin
      @(negedge hclk);
      c++;
    end while (periodic_out !== v && c < 400);
    hang(periodic_out === v ? 0 : c);
    @(posedge hclk);
  endtask : wait_out

  task automatic t_regs();
    logic [4:0] ix [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
      5'h06, 5'h07, 5'h08, 5'h0a, 5'h0c, 5'h10, 5'h11, 5'h12, 5'h13, 5'h15};
    for (int k = 0; k < 16; k++)
      rdc(ix[k], ix[k] == 5'h0a ? 32'hffff : 32'h0);
    wr(RPCS_IDX_LATCH, 32'ha5);
    rdc(RPCS_IDX_LATCH, 32'ha5);
    wr(RPCS_IDX_CLK_SRC, 32'h3);
    rdc(RPCS_IDX_CLK_SRC, 32'h3);
    wr(RPCS_IDX_BUSY, 32'hf);
    rdc(RPCS_IDX_BUSY, 32'h0);
    wr(5'h06, 32'hff);
    rdc(5'h06, 32'h0);
    wr(RPCS_IDX_IRQ_EN, 32'h3);
    wr(RPCS_IDX_PIRQ_EN, 32'h1);
    rdc(RPCS_IDX_IRQ_EN, 32'h3);
    rdc(RPCS_IDX_PIRQ_EN, 32'h1);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_sync();
    logic [4:0]  ri [5] = '{5'h08, 5'h0a, 5'h0c, 5'h00, 5'h10};
    logic [31:0] rv [5] = '{32'h10, 32'h13, 32'h12, 32'h80, 32'h18};
    logic [31:0] bv [5] = '{32'h2, 32'h4, 32'h8, 32'h1, 32'h1};
    for (int k = 0; k < 5; k++)
    begin
      wr(ri[k], rv[k]);
      rdc(k == 4 ? RPCS_IDX_PSTAT : RPCS_IDX_BUSY, bv[k]);
      settle();
      rdc(ri[k], rv[k]);
    end
    $display("t_sync done");
  endtask : t_sync

  task automatic t_count();
    wr(RPCS_IDX_CTL_A, 32'h1);
    settle();
    repeat (160) @(posedge hclk);
    wr(RPCS_IDX_CTL_A, 32'h0);
    settle();
    rdc(RPCS_IDX_IRQ_FLAGS, 32'h3);
    chk({31'h0, counter_irq}, 32'h1);
    wr(RPCS_IDX_IRQ_FLAGS, 32'h1);
    rdc(RPCS_IDX_IRQ_FLAGS, 32'h2);
    wr(RPCS_IDX_IRQ_FLAGS, 32'h0);
    rdc(RPCS_IDX_IRQ_FLAGS, 32'h2);
    chk({31'h0, counter_irq}, 32'h1);
    wr(RPCS_IDX_IRQ_FLAGS, 32'h2);
    rdc(RPCS_IDX_IRQ_FLAGS, 32'h0);
    chk({31'h0, counter_irq}, 32'h0);
    $display("t_count done");
  endtask : t_count

  task automatic rate(input logic [7:0] c, input int exp);
    logic [15:0] a;
    wr(RPCS_IDX_CTL_A, {24'h0, c});
    settle();
    xfer(1'b0, RPCS_IDX_VALUE, 32'h0);
    a = rdata[15:0];
    repeat (256) @(posedge hclk);
    xfer(1'b0, RPCS_IDX_VALUE, 32'h0);
    a = rdata[15:0] - a;
    chk({31'h0, a <= exp + 1 && a + 1 >= exp}, 32'h1);
  endtask : rate

  task automatic t_rate();
    wr(RPCS_IDX_TOP, 32'hffff);
    rate(8'h01, 16);
    rate(8'h11, 4);
    rate(8'h79, 0);
    rate(8'h00, 0);
    cpu_halted <= 1'b1;
    rate(8'h01, 0);
    wr(RPCS_IDX_DBG, 32'h1);
    rate(8'h01, 16);
    cpu_halted <= 1'b0;
    sleep_standby <= 1'b1;
    rate(8'h01, 0);
    rate(8'h81, 16);
    $display("t_rate done");
  endtask : t_rate

  task automatic t_pit();
    int   a;
    int   b;
    logic pv;
    wr(RPCS_IDX_PCTL, 32'h11);
    settle();
    wait_out(1'b1, a);
    wait_out(1'b0, a);
    wait_out(1'b1, b);
    chk(a, 64);
    chk(a + b, 128);
    look(3);
    chk({31'h0, periodic_irq}, 32'h1);
    @(posedge hclk);
    wr(RPCS_IDX_PIRQ_FLG, 32'h1);
    rdc(RPCS_IDX_PIRQ_FLG, 32'h0);
    cpu_halted <= 1'b1;
    look(4);
    chk({31'h0, periodic_out}, 32'h0);
    @(posedge hclk);
    cpu_halted <= 1'b0;
    look(4);
    chk({31'h0, periodic_irq}, 32'h1);
    wait_out(1'b0, a);
    wr(RPCS_IDX_PIRQ_FLG, 32'h1);
    cpu_halted <= 1'b1;
    look(4);
    @(posedge hclk);
    cpu_halted <= 1'b0;
    look(4);
    chk({31'h0, periodic_irq}, 32'h0);
    pv = periodic_out;
    @(posedge hclk);
    clk_en <= 1'b0;
    look(70);
    chk({31'h0, periodic_out}, {31'h0, pv});
    @(posedge hclk);
    clk_en <= 1'b1;
    $display("t_pit done");
  endtask : t_pit

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_sync();
    t_count();
    t_rate();
    t_pit();
    end_sim();
  end

endmodule : tb_rtc_pit_control_sync

bind rpcs_top rpcs_properties u_props (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .counter_clk_pin(counter_clk_pin), .cpu_halted(cpu_halted),
  .counter_irq(counter_irq), .periodic_irq(periodic_irq),
  .periodic_out(periodic_out)
);
